// [rtl/flash_page_erase_program.sv]
`timescale 1ns/1ps
module flash_page_erase_program
  import flash_seq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sysReset,
  // Special function register bus
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrEn,
  input  wire logic        sfrRdEn,
  input  wire logic [7:0]  sfrWrData,
  output logic      [7:0]  sfrRdData,
  // CPU
  input  wire logic        irq,
  output logic             cpuIdle,
  // High-voltage generator and security
  input  wire logic        hvAbortPin,
  input  wire logic        hvErrorPin,
  input  wire logic        secEraseOk,
  // Flash array
  output logic             arrayWr,
  output logic             arrayElem,
  output logic      [15:0] arrayAddr,
  output logic      [7:0]  arrayWdata,
  output logic      [7:0]  elemRdAddr,
  input  wire logic [7:0]  elemRdData
);

  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] off);
    hit = en && (a == off);
  endfunction

  function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  state_t                state_r, state_nxt;
  logic [TIMER_W-1:0]    timer_r, timer_nxt;
  logic [STATUS_W-1:0]   status_r, status_nxt;
  logic                  elemMode_r, elemMode_nxt;
  logic [7:0]            addrLow_r, addrLow_nxt;
  logic [7:0]            addrHigh_r, addrHigh_nxt;
  logic [7:0]            elemData_r, elemData_nxt;
  logic [7:0]            rdData_r, rdData_nxt;
  logic                  arrayWr_r, arrayWr_nxt;
  logic                  arrayElem_r, arrayElem_nxt;
  logic [15:0]           arrayAddr_r, arrayAddr_nxt;
  logic [7:0]            arrayWdata_r, arrayWdata_nxt;
  logic [1:0]            hvSync1_r, hvSync2_r;
  logic                  busy, idle, wrCmd, wrData, wrAdrL, wrAdrH, bufWr, bufClr;
  logic                  abortIrq, abortHv, rejectElem;
  logic [7:0]            bufRdData;
  logic                  bufRdFlag, anyFlag;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the analog flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hvSync1_r <= 2'h0;
      hvSync2_r <= 2'h0;
    end else begin
      hvSync1_r <= {hvAbortPin, hvErrorPin};
      hvSync2_r <= hvSync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; writes are ignored while the CPU is held idle
  assign busy     = (state_r != ST_IDLE);
  assign idle     = !busy;
  assign wrCmd    = hit(sfrWrEn && idle, sfrAddr, ADDR_CMD_STATUS);
  assign wrData   = hit(sfrWrEn && idle, sfrAddr, ADDR_DATA_PORT);
  assign wrAdrL   = hit(sfrWrEn && idle, sfrAddr, ADDR_ADDR_LOW);
  assign wrAdrH   = hit(sfrWrEn && idle, sfrAddr, ADDR_ADDR_HIGH);
  assign bufWr    = wrData && !elemMode_r && !sysReset;
  assign bufClr   = (wrCmd && (sfrWrData == CMD_LOAD)) || sysReset;
  assign abortIrq = busy && irq;
  assign abortHv  = busy && (|hvSync2_r);
  // Signatures are never written; security bytes only with permission
  assign rejectElem = inRange(addrLow_r, SIG_FIRST, SIG_LAST) ||
                      (inRange(addrLow_r, SEC_FIRST, SEC_LAST) && !secEraseOk);

  page_buffer #(
    .DEPTH  (BUF_DEPTH),
    .IDX_W  (IDX_W),
    .DATA_W (8)
  ) u_buf (
    .core_clk (core_clk),
    .rst      (rst),
    .clr      (bufClr),
    .wrEn     (bufWr),
    .wrIdx    (addrLow_r[IDX_W-1:0]),
    .wrData   (sfrWrData),
    .rdIdx    (timer_r[IDX_W-1:0]),
    .rdData   (bufRdData),
    .rdFlag   (bufRdFlag),
    .anyFlag  (anyFlag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt      = state_r;
    timer_nxt      = timer_r;
    status_nxt     = wrCmd ? STATUS_RESET : status_r;
    elemMode_nxt   = elemMode_r;
    addrLow_nxt    = addrLow_r;
    addrHigh_nxt   = addrHigh_r;
    elemData_nxt   = elemData_r;
    arrayWr_nxt    = 1'b0;
    arrayElem_nxt  = arrayElem_r;
    arrayAddr_nxt  = arrayAddr_r;
    arrayWdata_nxt = arrayWdata_r;
    case (state_r)
      ST_IDLE: begin
        if (wrCmd) begin
          case (sfrWrData)
            CMD_LOAD: elemMode_nxt = 1'b0;
            CMD_ERASE_PROG: begin
              elemMode_nxt = 1'b0;
              state_nxt    = ST_PAGE;
              timer_nxt    = TIMER_W'(PROG_CYCLES - 1);
            end
            CMD_ELEMENT: elemMode_nxt = 1'b1;
            default: ;
          endcase
        end
        if (wrAdrL) begin
          addrLow_nxt = sfrWrData;
        end
        if (wrAdrH) begin
          addrHigh_nxt = sfrWrData;
        end
        if (bufWr) begin
          // Index wraps inside the buffer; page bits stay put
          addrLow_nxt = {addrLow_r[7:IDX_W], addrLow_r[IDX_W-1:0] + 1'b1};
        end
        if (wrData && elemMode_r) begin
          if (rejectElem) begin
            status_nxt[BIT_SV] = 1'b1;
          end else begin
            state_nxt    = ST_ELEM;
            timer_nxt    = TIMER_W'(PROG_CYCLES - 1);
            elemData_nxt = sfrWrData;
          end
        end
      end
      ST_PAGE, ST_ELEM: begin
        if (abortIrq || abortHv) begin
          // Commits sit in the last BUF_DEPTH cycles, so an earlier abort leaves the array untouched
          state_nxt           = ST_IDLE;
          status_nxt[BIT_OI]  = abortIrq;
          status_nxt[BIT_HVA] = hvSync2_r[1];
          status_nxt[BIT_HVE] = hvSync2_r[0];
        end else begin
          timer_nxt = timer_r - 1'b1;
          if (timer_r == '0) begin
            state_nxt = ST_IDLE;
          end
          if ((state_r == ST_PAGE) && (timer_r < TIMER_W'(BUF_DEPTH)) && bufRdFlag) begin
            arrayWr_nxt    = 1'b1;
            arrayElem_nxt  = 1'b0;
            arrayAddr_nxt  = {addrHigh_r, addrLow_r[7:IDX_W], timer_r[IDX_W-1:0]};
            arrayWdata_nxt = bufRdData;
          end
          if ((state_r == ST_ELEM) && (timer_r == '0)) begin
            arrayWr_nxt    = 1'b1;
            arrayElem_nxt  = 1'b1;
            arrayAddr_nxt  = {8'h00, addrLow_r};
            arrayWdata_nxt = elemData_r;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (sysReset) begin
      state_nxt    = ST_IDLE;
      timer_nxt    = '0;
      elemMode_nxt = 1'b0;
      addrLow_nxt  = 8'h00;
      addrHigh_nxt = 8'h00;
      arrayWr_nxt  = 1'b0;
      status_nxt   = STATUS_RESET;
      status_nxt[BIT_OI] = busy;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      timer_r      <= '0;
      status_r     <= STATUS_RESET;
      elemMode_r   <= 1'b0;
      addrLow_r    <= 8'h00;
      addrHigh_r   <= 8'h00;
      elemData_r   <= 8'h00;
      arrayWr_r    <= 1'b0;
      arrayElem_r  <= 1'b0;
      arrayAddr_r  <= 16'h0000;
      arrayWdata_r <= 8'h00;
    end else begin
      state_r      <= state_nxt;
      timer_r      <= timer_nxt;
      status_r     <= status_nxt;
      elemMode_r   <= elemMode_nxt;
      addrLow_r    <= addrLow_nxt;
      addrHigh_r   <= addrHigh_nxt;
      elemData_r   <= elemData_nxt;
      arrayWr_r    <= arrayWr_nxt;
      arrayElem_r  <= arrayElem_nxt;
      arrayAddr_r  <= arrayAddr_nxt;
      arrayWdata_r <= arrayWdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, one cycle after the read strobe
  always_comb begin
    rdData_nxt = 8'h00;
    if (sfrRdEn) begin
      case (sfrAddr)
        ADDR_CMD_STATUS: rdData_nxt = {{(8 - STATUS_W){1'b0}}, status_r};
        ADDR_DATA_PORT:  rdData_nxt = elemMode_r ? elemRdData : 8'h00;
        ADDR_ADDR_LOW:   rdData_nxt = addrLow_r;
        ADDR_ADDR_HIGH:  rdData_nxt = addrHigh_r;
        default:         rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign sfrRdData  = rdData_r;
  assign cpuIdle    = busy;
  assign arrayWr    = arrayWr_r;
  assign arrayElem  = arrayElem_r;
  assign arrayAddr  = arrayAddr_r;
  assign arrayWdata = arrayWdata_r;
  assign elemRdAddr = addrLow_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [TIMER_W-1:0] busyCnt_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busyCnt_r <= '0;
    end else begin
      busyCnt_r <= busy ? busyCnt_r + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wrap_keeps_page: assert property (bufWr && (addrLow_r[3:0] == 4'hf) |=>
    (addrLow_r[3:0] == 4'h0) && (addrLow_r[7:4] == $past(addrLow_r[7:4])))
    else $error("buffer index did not wrap inside the page");
  a_data_increments: assert property (bufWr && !wrAdrL && (addrLow_r[3:0] != 4'hf) |=>
    addrLow_r == $past(addrLow_r) + 8'h01)
    else $error("low address did not advance after data write");
  a_start_holds_idle: assert property (wrCmd && (sfrWrData == CMD_ERASE_PROG) && !sysReset |=> cpuIdle)
    else $error("erase-program did not start the idle hold");
  a_idle_held: assert property (busy && (timer_r != '0) && !abortIrq && !abortHv && !sysReset |=> cpuIdle)
    else $error("CPU idle hold ended early");
  a_irq_sets_oi: assert property (abortIrq && !sysReset |=> !cpuIdle && status_r[BIT_OI])
    else $error("interrupt did not abort with interrupted flag");
  a_cmd_clears_status: assert property (wrCmd && !wrData && !sysReset |=>
    (status_r == STATUS_RESET) || cpuIdle)
    else $error("command write left status bits set");
  a_load_clears_flags: assert property (bufClr |=> !anyFlag)
    else $error("buffer clear left an update flag");
  a_data_sets_flag: assert property (bufWr && !bufClr |=> anyFlag)
    else $error("data write did not set an update flag");
  a_fixed_duration: assert property (busy && (timer_r == '0) && !abortIrq && !abortHv && !sysReset |->
    busyCnt_r == TIMER_W'(PROG_CYCLES - 1) ##1 !cpuIdle)
    else $error("erase-program length is wrong");
  a_page_target: assert property (arrayWr && !arrayElem |->
    arrayAddr[15:4] == {addrHigh_r, addrLow_r[7:4]})
    else $error("commit went outside the selected page");
  a_signature_reject: assert property (wrData && elemMode_r && !sysReset &&
    inRange(addrLow_r, SIG_FIRST, SIG_LAST) |=> status_r[BIT_SV] && !cpuIdle && !arrayWr [*2])
    else $error("signature byte was not refused");
  a_reset_abort: assert property (busy && sysReset |=> !cpuIdle && status_r[BIT_OI])
    else $error("system reset did not flag the aborted cycle");
  c_page_done: cover property (busy && (timer_r == '0) && !abortIrq && !abortHv ##1 arrayWr);
  c_interrupted: cover property (abortIrq ##1 status_r[BIT_OI]);
  c_elem_read: cover property (sfrRdEn && elemMode_r && (sfrAddr == ADDR_DATA_PORT));
  c_sig_reject: cover property (wrData && elemMode_r && rejectElem);

endmodule

// [shared/flash_seq_pkg.sv]
// How it works
// - Index increment past last buffer byte wraps, page bits untouched
// - Buffer bytes load in any order at any rewritten address
// - Target page is high address plus low address bits 7:4
// - Only flagged buffer bytes are programmed; others untouched
// - Command 68H starts the cycle and holds the CPU idle
// - Status of the finished cycle is readable after idle ends
// - Interrupt during the cycle aborts it and sets bit 0
// - Cycle lasts a fixed 4 ms regardless of flagged bytes
// - Command 00H clears all buffer bytes and update flags
// - Buffer load index comes from low address bits, not page bits
// - Each data port write outside element mode advances the low address register
// - Status reads back; any command write clears all status bits
// - Signature bytes refuse programming; security erase needs permission
// - In element mode the low address alone picks the element
// - Buffer holds 16 bytes, each with its own update flag
// - Data write stores the byte and sets its update flag
// - Command 6CH selects element mode; write programs, read returns
package flash_seq_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_CMD_STATUS = 8'he4;
  localparam logic [7:0] ADDR_DATA_PORT  = 8'he5;
  localparam logic [7:0] ADDR_ADDR_LOW   = 8'he6;
  localparam logic [7:0] ADDR_ADDR_HIGH  = 8'he7;

  // Commands
  localparam logic [7:0] CMD_LOAD       = 8'h00;
  localparam logic [7:0] CMD_ERASE_PROG = 8'h68;
  localparam logic [7:0] CMD_ELEMENT    = 8'h6c;

  // Status field
  localparam int         STATUS_W     = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam int         BIT_OI       = 0;
  localparam int         BIT_SV       = 1;
  localparam int         BIT_HVE      = 2;
  localparam int         BIT_HVA      = 3;

  // Element address classes
  localparam logic [7:0] SEC_FIRST = 8'h08;
  localparam logic [7:0] SEC_LAST  = 8'h0b;
  localparam logic [7:0] SIG_FIRST = 8'h10;
  localparam logic [7:0] SIG_LAST  = 8'h12;

  // Page buffer
  localparam int BUF_DEPTH = 16;
  localparam int IDX_W     = 4;

  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PROG_TIME_MS    = 4;
  localparam int PROG_CYCLES_DEF = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W         = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PAGE = 2'b01,
    ST_ELEM = 2'b10
  } state_t;

endpackage

// [rtl/page_buffer.sv]
`timescale 1ns/1ps
module page_buffer #(
  parameter int DEPTH  = 16,
  parameter int IDX_W  = 4,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Load side
  input  wire logic              clr,
  input  wire logic              wrEn,
  input  wire logic [IDX_W-1:0]  wrIdx,
  input  wire logic [DATA_W-1:0] wrData,
  // Commit side
  input  wire logic [IDX_W-1:0]  rdIdx,
  output logic      [DATA_W-1:0] rdData,
  output logic                   rdFlag,
  output logic                   anyFlag
);

  logic [DATA_W-1:0] mem_r   [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];
  logic [DEPTH-1:0]  flag_r;
  logic [DEPTH-1:0]  flag_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Clear has priority: a write in the same cycle is not kept
  always_comb begin
    mem_nxt  = mem_r;
    flag_nxt = flag_r;
    if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_nxt[i] = '0;
      end
      flag_nxt = '0;
    end else if (wrEn) begin
      mem_nxt[wrIdx]  = wrData;
      flag_nxt[wrIdx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      flag_r <= '0;
    end else begin
      mem_r  <= mem_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign rdData  = mem_r[rdIdx];
  assign rdFlag  = flag_r[rdIdx];
  assign anyFlag = |flag_r;

endmodule

// [sim/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
  // Clock
  input  wire logic        core_clk,
  // Write side
  input  wire logic        arrayWr,
  input  wire logic        arrayElem,
  input  wire logic [15:0] arrayAddr,
  input  wire logic [7:0]  arrayWdata,
  // Element read side
  input  wire logic [7:0]  elemRdAddr,
  output logic      [7:0]  elemRdData
);
  logic [7:0] mem [int];
  int         nWrites = 0;

  // Element space sits above the 64K code space in one shared map
  always @(posedge core_clk) begin
    if (arrayWr) begin
      mem[arrayElem ? 32'h10000 + arrayAddr : 32'h0 + arrayAddr] = arrayWdata;
      nWrites++;
    end
  end

  // Never-written cells return the inverted address, so a stale byte cannot pass for data
  always @(elemRdAddr or nWrites) begin
    if (mem.exists(32'h10000 + elemRdAddr)) begin
      elemRdData = mem[32'h10000 + elemRdAddr];
    end else begin
      elemRdData = ~elemRdAddr;
    end
  end
endmodule

// [sim/test_flash_page_erase_program.sv]
`timescale 1ns/1ps
module test_flash_page_erase_program;
  import flash_seq_pkg::*;
  localparam int unsigned PC = 40;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sysReset = 1'b0;
  logic [7:0]  sfrAddr = 8'h00;
  logic        sfrWrEn = 1'b0;
  logic        sfrRdEn = 1'b0;
  logic [7:0]  sfrWrData = 8'h00;
  logic [7:0]  sfrRdData;
  logic        irq = 1'b0;
  logic        cpuIdle;
  logic        secEraseOk = 1'b0;
  logic        arrayWr;
  logic        arrayElem;
  logic [15:0] arrayAddr;
  logic [7:0]  arrayWdata;
  logic [7:0]  elemRdAddr;
  logic [7:0]  elemRdData;
  int          nFail = 0;
  int          totalChecks = 0;

  always #50 core_clk = ~core_clk;

  flash_page_erase_program #(.PROG_CYCLES(PC)) i_dut (
    .core_clk(core_clk), .rst(rst), .sysReset(sysReset),
    .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .irq(irq), .cpuIdle(cpuIdle), .hvAbortPin(1'b0), .hvErrorPin(1'b0), .secEraseOk(secEraseOk),
    .arrayWr(arrayWr), .arrayElem(arrayElem), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
    .elemRdAddr(elemRdAddr), .elemRdData(elemRdData)
  );

  flash_array_model i_array (
    .core_clk(core_clk), .arrayWr(arrayWr), .arrayElem(arrayElem), .arrayAddr(arrayAddr),
    .arrayWdata(arrayWdata), .elemRdAddr(elemRdAddr), .elemRdData(elemRdData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrAddr   <= a;
    sfrWrData <= d;
    sfrWrEn   <= 1'b1;
    @(posedge core_clk);
    sfrWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge core_clk);
    sfrRdEn <= 1'b0;
    #1 d = sfrRdData;
  endtask

  // Counts busy cycles; the bound keeps a stuck idle from hanging the run
  task automatic waitIdle(output int n);
    n = 0;
    #1;
    while (cpuIdle === 1'b1 && n < 1000) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  task automatic status(input logic [7:0] e);
    logic [7:0] s;
    rd(ADDR_CMD_STATUS, s);
    chk("status", {24'h0, e}, {24'h0, s});
  endtask

  task automatic startProg(input int expBusy);
    int n;
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    waitIdle(n);
    chk("busy cycles", expBusy, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tPage();
    int w0;
    w0 = i_array.nWrites;
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    wr(ADDR_ADDR_HIGH, 8'h12);
    wr(ADDR_ADDR_LOW, 8'h3e);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_DATA_PORT, 8'ha0 + 8'(i));
    end
    wr(ADDR_ADDR_LOW, 8'h35);
    wr(ADDR_DATA_PORT, 8'hc5);
    startProg(PC);
    status(8'h00);
    chk("byte e", 8'ha0, i_array.mem[32'h123e]);
    chk("byte f", 8'ha1, i_array.mem[32'h123f]);
    chk("wrap byte", 8'ha2, i_array.mem[32'h1230]);
    chk("moved byte", 8'hc5, i_array.mem[32'h1235]);
    chk("no page spill", 0, i_array.mem.exists(32'h1240));
    chk("write count", w0 + 4, i_array.nWrites);
  endtask

  task automatic tClear();
    int w0;
    w0 = i_array.nWrites;
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    wr(ADDR_ADDR_LOW, 8'h47);
    wr(ADDR_DATA_PORT, 8'h77);
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    startProg(PC);
    chk("cleared buffer writes", w0, i_array.nWrites);
  endtask

  task automatic tAbort(input bit useReset);
    int w0;
    w0 = i_array.nWrites;
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    wr(ADDR_ADDR_LOW, 8'h50);
    wr(ADDR_DATA_PORT, 8'h99);
    wr(ADDR_CMD_STATUS, CMD_ERASE_PROG);
    repeat (5) @(posedge core_clk);
    if (useReset) sysReset <= 1'b1;
    else irq <= 1'b1;
    @(posedge core_clk);
    sysReset <= 1'b0;
    irq      <= 1'b0;
    #1 chk("idle after abort", 0, cpuIdle);
    status(8'h01);
    chk("aborted writes", w0, i_array.nWrites);
    wr(ADDR_CMD_STATUS, 8'hff);
    status(8'h00);
    // Redo from the buffer clear; a system reset has also cleared the high address
    wr(ADDR_CMD_STATUS, CMD_LOAD);
    wr(ADDR_ADDR_LOW, 8'h50);
    wr(ADDR_DATA_PORT, 8'h99);
    startProg(PC);
    status(8'h00);
    chk("redo byte", 8'h99, i_array.mem[useReset ? 32'h0050 : 32'h1250]);
  endtask

  task automatic tElement();
    logic [7:0] d;
    wr(ADDR_ADDR_LOW, 8'h02);
    wr(ADDR_CMD_STATUS, CMD_ELEMENT);
    wr(ADDR_DATA_PORT, 8'h5a);
    begin
      int n;
      waitIdle(n);
      chk("element busy", PC, n);
    end
    repeat (2) @(posedge core_clk);
    chk("element stored", 8'h5a, i_array.mem[32'h10002]);
    wr(ADDR_CMD_STATUS, CMD_ELEMENT);
    rd(ADDR_DATA_PORT, d);
    chk("element read", 8'h5a, d);
    wr(ADDR_ADDR_LOW, 8'h03);
    rd(ADDR_DATA_PORT, d);
    chk("element read 3", 8'hfc, d);
  endtask

  task automatic tProtect();
    logic [7:0] addrs [4] = '{8'h10, 8'h11, 8'h12, 8'h08};
    int w0;
    w0 = i_array.nWrites;
    foreach (addrs[i]) begin
      wr(ADDR_ADDR_LOW, addrs[i]);
      wr(ADDR_CMD_STATUS, CMD_ELEMENT);
      wr(ADDR_DATA_PORT, 8'h3c);
      @(posedge core_clk);
      #1 chk("protected idle", 0, cpuIdle);
      status(8'h02);
    end
    chk("protected writes", w0, i_array.nWrites);
    secEraseOk <= 1'b1;
    wr(ADDR_CMD_STATUS, CMD_ELEMENT);
    wr(ADDR_DATA_PORT, 8'h3c);
    begin
      int n;
      waitIdle(n);
      chk("security busy", PC, n);
    end
    repeat (2) @(posedge core_clk);
    chk("security stored", 8'h3c, i_array.mem[32'h10008]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("idle at reset", 0, cpuIdle);
    status(8'h00);
    tPage();
    tClear();
    tAbort(1'b0);
    tAbort(1'b1);
    tElement();
    tProtect();
    summarize();
  end

  // Whole run is about 400 cycles; this limit is generous
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    summarize();
  end
endmodule
